// ### bli_defines.svh
// constants for the backlight two-wire control port
`ifndef BLI_DEFINES_SVH
`define BLI_DEFINES_SVH
// fixed 7-bit target address
`define BLI_CHIP_ADDR 7'h38
// direction bit values
`define BLI_RW_WRITE 1'b0
`define BLI_RW_READ 1'b1
// register holding the soft reset bit and its position
`define BLI_REG_SWRST 8'h00
`define BLI_SWRST_BIT 0
// reset value of every control register
`define BLI_REG_RST 8'h00
// bits per byte
`define BLI_BYTE_BITS 4'h8
// system clock period and serial clock period, ns
`define BLI_CLK_NS 50
`define BLI_SCL_NS 1000
// system clocks per quarter of a serial clock period
`define BLI_QTR_CYC (`BLI_SCL_NS / (4 * `BLI_CLK_NS))
`endif

// ### bli_pkg.sv
// types shared by both ends of the control port
`default_nettype none
package bli_pkg;
	// target end states, one-hot
	typedef enum logic [7:0] {
		BLI_S_IDLE = 8'h01,
		BLI_S_ADDR = 8'h02,
		BLI_S_AACK = 8'h04,
		BLI_S_WR = 8'h08,
		BLI_S_WACK = 8'h10,
		BLI_S_RD = 8'h20,
		BLI_S_RACK = 8'h40,
		BLI_S_IGN = 8'h80
	} bli_dev_st_t;
	// controller end states, one-hot
	typedef enum logic [3:0] {
		BLI_H_IDLE = 4'h1,
		BLI_H_START = 4'h2,
		BLI_H_BIT = 4'h4,
		BLI_H_STOP = 4'h8
	} bli_host_st_t;
endpackage
`default_nettype wire

// ### bli_if.sv
// two-wire link between controller and target, with wired-and resolution
`timescale 1ns/1ns
`default_nettype none
interface bli_if;
	logic scl_o; // controller clock drive value
	logic scl_oe; // controller pulls clock
	logic m_sda_o; // controller data drive value
	logic m_sda_oe; // controller pulls data
	logic s_sda_o; // target data drive value
	logic s_sda_oe; // target pulls data
	logic hw_enable_reset_pin; // enable and reset pin, low resets target
	logic scl; // resolved clock line
	logic sda; // resolved data line
	// open-drain lines with pull-ups
	assign scl = !(scl_oe && !scl_o);
	assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);
	modport host(output scl_o, scl_oe, m_sda_o, m_sda_oe, hw_enable_reset_pin, input sda);
	modport dev(output s_sda_o, s_sda_oe, input scl, sda, hw_enable_reset_pin);
endinterface
`default_nettype wire

// ### bli_dev.sv
// target end: control port with register file, soft and pin reset
`timescale 1ns/1ns
`default_nettype none
`include "bli_defines.svh"
module bli_dev
	import bli_pkg::*;
#(
	parameter int NREG = 16 // number of control registers
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	bli_if.dev bus, // two-wire link
	output logic dev_enabled, // high once out of reset
	output logic bus_busy, // between start and stop
	output logic wr_stb, // one-cycle pulse per data byte written
	output logic [7:0] wr_addr, // register just written
	output logic [7:0] wr_data, // value just written
	output logic [NREG*8-1:0] regs // register file, word i at [8i+:8]
);
	logic arst_n; // pin or system reset
	logic [1:0] rs_q, rs_d; // reset release synchroniser
	logic rs_n; // synchronised reset
	logic [2:0] sc_q, sc_d; // clock line synchroniser
	logic [2:0] sd_q, sd_d; // data line synchroniser
	logic sclf_q, sclf_d; // accepted clock level
	logic sdaf_q, sdaf_d; // accepted data level
	logic scl_chg, sda_chg; // accepted level changes now
	logic scl_rise, scl_fall; // clock edges
	logic start_ev, stop_ev; // bus conditions
	bli_dev_st_t st_q, st_d; // protocol state
	logic [3:0] cnt_q, cnt_d; // bit counter
	logic [7:0] sh_q, sh_d; // shift register
	logic rw_q, rw_d; // direction of transfer
	logic first_q, first_d; // next write byte is the pointer
	logic [7:0] ptr_q, ptr_d; // register pointer
	logic oe_q, oe_d; // pull data low
	logic busy_q, busy_d; // bus busy flag
	logic wstb_q, wstb_d; // write strobe
	logic [7:0] wa_q, wa_d; // write address
	logic [7:0] wv_q, wv_d; // write value
	logic [NREG*8-1:0] rg_q, rg_d; // register storage

	// value of a register, zero outside the file
	function automatic logic [7:0] rd_byte(input logic [NREG*8-1:0] r, input logic [7:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (int'(a) < NREG) begin
			v = r[int'(a)*8 +: 8];
		end
		return v;
	endfunction
	// the pin acts on the reset without the clock
	assign arst_n = rst_n & bus.hw_enable_reset_pin;
	// reset release synchroniser, next value
	always_comb begin
		rs_d = {rs_q[0], 1'b1};
	end
	// reset release synchroniser, registers
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rs_q <= 2'h0;
		end else begin
			rs_q <= rs_d;
		end
	end
	assign rs_n = rs_q[1];
	// pin synchronisers: a change counts once stages two and three agree
	always_comb begin
		sc_d = {sc_q[1:0], bus.scl};
		sd_d = {sd_q[1:0], bus.sda};
		scl_chg = (sc_q[1] == sc_q[2]) && (sc_q[2] != sclf_q);
		sda_chg = (sd_q[1] == sd_q[2]) && (sd_q[2] != sdaf_q);
		sclf_d = scl_chg ? sc_q[2] : sclf_q;
		sdaf_d = sda_chg ? sd_q[2] : sdaf_q;
		scl_rise = scl_chg && sc_q[2];
		scl_fall = scl_chg && !sc_q[2];
		// clock held high and steady while data moves
		start_ev = sda_chg && !sd_q[2] && sclf_q && !scl_chg;
		stop_ev = sda_chg && sd_q[2] && sclf_q && !scl_chg;
	end
	// pin synchronisers, registers
	always_ff @(posedge clk or negedge rs_n) begin
		if (!rs_n) begin
			sc_q <= 3'h7;
			sd_q <= 3'h7;
			sclf_q <= 1'b1;
			sdaf_q <= 1'b1;
		end else begin
			sc_q <= sc_d;
			sd_q <= sd_d;
			sclf_q <= sclf_d;
			sdaf_q <= sdaf_d;
		end
	end
	// protocol engine, next values
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		rw_d = rw_q;
		first_d = first_q;
		ptr_d = ptr_q;
		oe_d = oe_q;
		busy_d = busy_q;
		wstb_d = 1'b0;
		wa_d = wa_q;
		wv_d = wv_q;
		rg_d = rg_q;
		if (start_ev) begin
			// a repeated start is taken the same as a first one
			st_d = BLI_S_ADDR;
			cnt_d = 4'h0;
			oe_d = 1'b0;
			busy_d = 1'b1;
		end else if (stop_ev) begin
			st_d = BLI_S_IDLE;
			oe_d = 1'b0;
			busy_d = 1'b0;
		end else begin
			case (st_q)
				BLI_S_ADDR: begin
					// shift address and direction in, msb first
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sdaf_q};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == `BLI_BYTE_BITS) begin
						if (sh_q[7:1] == `BLI_CHIP_ADDR) begin
							oe_d = 1'b1;
							rw_d = sh_q[0];
							first_d = 1'b1;
							st_d = BLI_S_AACK;
						end else begin
							// not ours: stay off the bus
							st_d = BLI_S_IGN;
						end
					end
				end
				BLI_S_AACK: begin
					// end of ninth pulse: release or put out first bit
					if (scl_fall) begin
						if (rw_q == `BLI_RW_READ) begin
							sh_d = rd_byte(rg_q, ptr_q);
							oe_d = !sh_d[7];
							cnt_d = 4'h1;
							st_d = BLI_S_RD;
						end else begin
							oe_d = 1'b0;
							cnt_d = 4'h0;
							st_d = BLI_S_WR;
						end
					end
				end
				BLI_S_WR: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sdaf_q};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == `BLI_BYTE_BITS) begin
						oe_d = 1'b1;
						st_d = BLI_S_WACK;
						if (first_q) begin
							// first byte picks the register
							ptr_d = sh_q;
							first_d = 1'b0;
						end else begin
							// data byte: report it, then store or soft reset
							wstb_d = 1'b1;
							wa_d = ptr_q;
							wv_d = sh_q;
							if (ptr_q == `BLI_REG_SWRST && sh_q[`BLI_SWRST_BIT]) begin
								// soft reset: all defaults, bit reads back zero
								rg_d = {NREG{`BLI_REG_RST}};
							end else if (int'(ptr_q) < NREG) begin
								rg_d[int'(ptr_q)*8 +: 8] = sh_q;
							end
						end
					end
				end
				BLI_S_WACK: begin
					// release after the ninth pulse
					if (scl_fall) begin
						oe_d = 1'b0;
						cnt_d = 4'h0;
						st_d = BLI_S_WR;
					end
				end
				BLI_S_RD: begin
					// put out next bit while the clock is low
					if (scl_fall) begin
						if (cnt_q == `BLI_BYTE_BITS) begin
							oe_d = 1'b0;
							st_d = BLI_S_RACK;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							oe_d = !sh_q[6];
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
				BLI_S_RACK: begin
					// controller answer on the ninth pulse
					if (scl_rise) begin
						st_d = sdaf_q ? BLI_S_IGN : BLI_S_AACK;
					end
				end
				default: begin
					// idle or ignoring: data line left released
					oe_d = 1'b0;
				end
			endcase
		end
	end
	// protocol engine, registers
	always_ff @(posedge clk or negedge rs_n) begin
		if (!rs_n) begin
			st_q <= BLI_S_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			rw_q <= 1'b0;
			first_q <= 1'b0;
			ptr_q <= 8'h00;
			oe_q <= 1'b0;
			busy_q <= 1'b0;
			wstb_q <= 1'b0;
			wa_q <= 8'h00;
			wv_q <= 8'h00;
			rg_q <= {NREG{`BLI_REG_RST}};
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			rw_q <= rw_d;
			first_q <= first_d;
			ptr_q <= ptr_d;
			oe_q <= oe_d;
			busy_q <= busy_d;
			wstb_q <= wstb_d;
			wa_q <= wa_d;
			wv_q <= wv_d;
			rg_q <= rg_d;
		end
	end
	// outputs straight from flip-flops
	assign bus.s_sda_o = 1'b0;
	assign bus.s_sda_oe = oe_q;
	assign dev_enabled = rs_q[1];
	assign bus_busy = busy_q;
	assign wr_stb = wstb_q;
	assign wr_addr = wa_q;
	assign wr_data = wv_q;
	assign regs = rg_q;
endmodule
`default_nettype wire

// ### bli_host.sv
// controller end: makes the serial clock, writes and reads one register
`timescale 1ns/1ns
`default_nettype none
`include "bli_defines.svh"
module bli_host
	import bli_pkg::*;
#(
	parameter int QTR = `BLI_QTR_CYC // system clocks per quarter clock period
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	bli_if.host bus, // two-wire link
	input wire logic en_req, // desired enable pin level
	input wire logic req, // start a transfer while idle
	input wire logic rw, // 0 write, 1 read
	input wire logic [7:0] reg_addr, // target register
	input wire logic [7:0] wdata, // value to write
	output logic busy, // transfer in progress
	output logic done, // one-cycle pulse at end
	output logic nack, // a byte went unanswered
	output logic [7:0] rdata // byte read back
);
	bli_host_st_t st_q, st_d; // sequencer state
	logic [7:0] tc_q, tc_d; // quarter timer
	logic [1:0] q_q, q_d; // quarter index
	logic [3:0] bn_q, bn_d; // bit index in byte
	logic [1:0] bi_q, bi_d; // byte index in transfer
	logic [7:0] sh_q, sh_d; // shift register
	logic scl_q, scl_d; // pull clock low
	logic oe_q, oe_d; // pull data low
	logic busy_q, busy_d, done_q, done_d, nack_q, nack_d; // status
	logic [7:0] rd_q, rd_d; // read result
	logic rw_q, rw_d; // latched direction
	logic [7:0] ra_q, ra_d, wd_q, wd_d; // latched address and data
	logic [2:0] sd_q, sd_d; // data line synchroniser
	logic sdaf_q, sdaf_d; // accepted data level
	logic hw_q, hw_d; // enable pin drive
	logic tk; // end of quarter
	logic last; // final byte of the transfer

	// byte sent in each slot of a transfer
	function automatic logic [7:0] byte_of(input logic [1:0] i, input logic r, input logic [7:0] a,
		input logic [7:0] w);
		logic [7:0] v;
		v = 8'hff;
		case (i)
			2'h0: v = {`BLI_CHIP_ADDR, `BLI_RW_WRITE};
			2'h1: v = a;
			2'h2: v = r ? {`BLI_CHIP_ADDR, `BLI_RW_READ} : w;
			default: v = 8'hff;
		endcase
		return v;
	endfunction

	// sequencer, next values
	always_comb begin
		st_d = st_q;
		tc_d = tc_q;
		q_d = q_q;
		bn_d = bn_q;
		bi_d = bi_q;
		sh_d = sh_q;
		scl_d = scl_q;
		oe_d = oe_q;
		busy_d = busy_q;
		done_d = 1'b0;
		nack_d = nack_q;
		rd_d = rd_q;
		rw_d = rw_q;
		ra_d = ra_q;
		wd_d = wd_q;
		hw_d = en_req;
		sd_d = {sd_q[1:0], bus.sda};
		sdaf_d = (sd_q[1] == sd_q[2]) ? sd_q[2] : sdaf_q;
		tk = (tc_q == 8'(QTR - 1));
		last = rw_q ? (bi_q == 2'h3) : (bi_q == 2'h2);
		if (st_q != BLI_H_IDLE) begin
			tc_d = tk ? 8'h00 : tc_q + 8'h01;
			q_d = tk ? q_q + 2'h1 : q_q;
		end
		case (st_q)
			BLI_H_IDLE: begin
				if (req) begin
					rw_d = rw;
					ra_d = reg_addr;
					wd_d = wdata;
					busy_d = 1'b1;
					nack_d = 1'b0;
					bi_d = 2'h0;
					tc_d = 8'h00;
					q_d = 2'h0;
					st_d = BLI_H_START;
				end
			end
			BLI_H_START: begin
				// only this end makes start conditions
				if (tk) begin
					case (q_q)
						2'h0: scl_d = 1'b0;
						2'h1: oe_d = 1'b1;
						2'h2: scl_d = 1'b1;
						default: begin
							sh_d = byte_of(bi_q, rw_q, ra_q, wd_q);
							oe_d = !sh_d[7];
							bn_d = 4'h0;
							st_d = BLI_H_BIT;
						end
					endcase
				end
			end
			BLI_H_BIT: begin
				if (tk) begin
					case (q_q)
						2'h0: scl_d = 1'b0;
						2'h1: begin
						end
						2'h2: begin
							// sample at the end of the high phase, as the clock is pulled low
							scl_d = 1'b1;
							if (bn_q < `BLI_BYTE_BITS) begin
								sh_d = {sh_q[6:0], sdaf_q};
							end else if (sdaf_q && bi_q != 2'h3) begin
								nack_d = 1'b1;
							end
						end
						default: begin
							// clock is low: change data now
							bn_d = bn_q + 4'h1;
							if (bn_q == `BLI_BYTE_BITS) begin
								if (nack_q || last) begin
									oe_d = 1'b1;
									st_d = BLI_H_STOP;
								end else if (rw_q && bi_q == 2'h1) begin
									oe_d = 1'b0;
									bi_d = 2'h2;
									st_d = BLI_H_START;
								end else begin
									bi_d = bi_q + 2'h1;
									sh_d = byte_of(bi_d, rw_q, ra_q, wd_q);
									oe_d = !sh_d[7];
									bn_d = 4'h0;
								end
							end else if (bn_q == 4'h7) begin
								oe_d = 1'b0;
							end else begin
								oe_d = !sh_q[7];
							end
						end
					endcase
				end
			end
			default: begin
				// stop: data rises while the clock is high
				if (tk) begin
					case (q_q)
						2'h0: scl_d = 1'b0;
						2'h1: oe_d = 1'b0;
						2'h2: begin
						end
						default: begin
							rd_d = sh_q;
							busy_d = 1'b0;
							done_d = 1'b1;
							st_d = BLI_H_IDLE;
						end
					endcase
				end
			end
		endcase
	end

	// sequencer, registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= BLI_H_IDLE;
			tc_q <= 8'h00;
			q_q <= 2'h0;
			bn_q <= 4'h0;
			bi_q <= 2'h0;
			sh_q <= 8'h00;
			scl_q <= 1'b0;
			oe_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			nack_q <= 1'b0;
			rd_q <= 8'h00;
			rw_q <= 1'b0;
			ra_q <= 8'h00;
			wd_q <= 8'h00;
			sd_q <= 3'h7;
			sdaf_q <= 1'b1;
			hw_q <= 1'b0;
		end else begin
			st_q <= st_d;
			tc_q <= tc_d;
			q_q <= q_d;
			bn_q <= bn_d;
			bi_q <= bi_d;
			sh_q <= sh_d;
			scl_q <= scl_d;
			oe_q <= oe_d;
			busy_q <= busy_d;
			done_q <= done_d;
			nack_q <= nack_d;
			rd_q <= rd_d;
			rw_q <= rw_d;
			ra_q <= ra_d;
			wd_q <= wd_d;
			sd_q <= sd_d;
			sdaf_q <= sdaf_d;
			hw_q <= hw_d;
		end
	end

	// outputs straight from flip-flops
	assign bus.scl_o = 1'b0;
	assign bus.scl_oe = scl_q;
	assign bus.m_sda_o = 1'b0;
	assign bus.m_sda_oe = oe_q;
	assign bus.hw_enable_reset_pin = hw_q;
	assign busy = busy_q;
	assign done = done_q;
	assign nack = nack_q;
	assign rdata = rd_q;
endmodule
`default_nettype wire

// ### bli_link_asserts.sv
// concurrent checks on the two-wire link between controller and target
`timescale 1ns/1ns
`default_nettype none
`include "bli_defines.svh"
module bli_link_asserts (
	input wire logic clk, // system clock
	input wire logic rst_n, // asynchronous reset, active low
	input wire logic scl_o, // controller clock value
	input wire logic scl_oe, // controller pulls clock
	input wire logic m_sda_o, // controller data value
	input wire logic m_sda_oe, // controller pulls data
	input wire logic s_sda_o, // target data value
	input wire logic s_sda_oe, // target pulls data
	input wire logic hw_enable_reset_pin, // target enable pin
	input wire logic scl, // resolved clock line
	input wire logic sda // resolved data line
);
	logic scl_q; // clock level one cycle ago
	logic sda_q; // data level one cycle ago
	logic [7:0] cnt_q; // clock rises since last start, saturating
	logic [7:0] cnt_d; // next rise count
	logic [7:0] sh_q; // last eight bits on the wire
	logic [7:0] sh_d; // next shift value
	logic start; // start seen this cycle
	logic stop; // stop seen this cycle
	logic rise; // clock rise this cycle
	// next values of the link tracker
	always_comb begin
		start = scl && scl_q && sda_q && !sda;
		stop = scl && scl_q && !sda_q && sda;
		rise = scl && !scl_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		if (start) begin
			cnt_d = 8'h00;
		end else if (rise && cnt_q != 8'hff) begin
			cnt_d = cnt_q + 8'h01;
		end
		if (rise) begin
			sh_d = {sh_q[6:0], sda};
		end
	end
	// link tracker registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			cnt_q <= 8'h00;
			sh_q <= 8'h00;
		end else begin
			scl_q <= scl;
			sda_q <= sda;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	AST_TGT_STABLE: assert property (scl && scl_q |-> $stable(s_sda_oe))
		else $error("target changed data while clock high");
	AST_TGT_NO_COND: assert property ($rose(s_sda_oe) |-> !scl)
		else $error("target pulled data with clock high");
	AST_PIN_RELEASE: assert property (!hw_enable_reset_pin |-> !s_sda_oe)
		else $error("target drives data while disabled");
	AST_ACK_HOLD: assert property (s_sda_oe && $rose(scl) |-> s_sda_oe [*8])
		else $error("target let go of data during clock high");
	AST_ADDR_QUIET: assert property (cnt_q < 8'h08 |-> !s_sda_oe)
		else $error("target drives data during address bits");
	AST_ACK_ADDR: assert property (scl_q && !scl && hw_enable_reset_pin && cnt_q == 8'h08
		&& sh_q[7:1] == `BLI_CHIP_ADDR |-> ##[1:8] s_sda_oe)
		else $error("matching address not acknowledged");
	AST_START_FREE: assert property (start |-> !s_sda_oe)
		else $error("target held data at start");
	AST_STOP_QUIET: assert property (stop |=> !s_sda_oe [*8])
		else $error("target drives data after stop");
	cover property (start);
	// acknowledge pulses sit at rises 9, 18 and 27 after a start
	AST_HOST_ACK_REL: assert property ((cnt_q == 8'h09 || cnt_q == 8'h12 || cnt_q == 8'h1b)
		&& scl && scl_q |-> !m_sda_oe)
		else $error("controller held data during an acknowledge pulse");
	cover property (stop);
	// target drives a zero bit of a read byte
	cover property (cnt_q > 8'h09 && cnt_q < 8'h12 && scl && s_sda_oe);
endmodule
`default_nettype wire

// ### tb_backlight_i2c_slave_with_hw_reset.sv
// self-checking bench joining controller and target ends, plus a hand-driven target
`timescale 1ns/1ns
`default_nettype none
module tb_backlight_i2c_slave_with_hw_reset;
	logic clk = 1'b0; // system clock
	logic rst_n = 1'b0; // reset, active low
	logic en_req = 1'b0; // desired enable pin level
	logic req = 1'b0; // transfer request
	logic rw = 1'b0; // direction of transfer
	logic [7:0] reg_addr = 8'h00; // register pointer
	logic [7:0] wdata = 8'h00; // value to write
	logic busy, done, nack, dev_enabled, bus_busy, wr_stb; // status outputs
	logic [7:0] rdata, wr_addr, wr_data; // data outputs
	logic [127:0] regs; // first target register file
	logic [127:0] regs2; // hand-driven target register file
	logic [1:0] mid_busy; // host and target busy sampled mid-transfer
	logic ack; // acknowledge seen by the hand driver
	logic scl_p = 1'b1; // previous clock level
	logic sda_p = 1'b1; // previous data level
	logic [3:0] mon_n = 4'h8; // bits seen since start
	logic [7:0] mon_b = 8'h00; // first byte after start
	int fail_count = 0; // mismatches
	int check_count = 0; // comparisons
	int stb_count = 0; // write strobes
	bli_if bi(); // link between the design ends
	bli_if bx(); // link driven by hand
	always #25 clk = ~clk;
	bli_host #(.QTR(5)) u_bli_host (.clk(clk), .rst_n(rst_n), .bus(bi.host), .en_req(en_req), .req(req),
		.rw(rw), .reg_addr(reg_addr), .wdata(wdata), .busy(busy), .done(done), .nack(nack), .rdata(rdata));
	bli_dev #(.NREG(16)) u_bli_dev (.clk(clk), .rst_n(rst_n), .bus(bi.dev), .dev_enabled(dev_enabled),
		.bus_busy(bus_busy), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data), .regs(regs));
	bli_dev #(.NREG(16)) u_bli_dev_2 (.clk(clk), .rst_n(rst_n), .bus(bx.dev), .dev_enabled(),
		.bus_busy(), .wr_stb(), .wr_addr(), .wr_data(), .regs(regs2));
	bli_link_asserts u_bli_link_asserts (.clk(clk), .rst_n(rst_n), .scl_o(bi.scl_o), .scl_oe(bi.scl_oe),
		.m_sda_o(bi.m_sda_o), .m_sda_oe(bi.m_sda_oe), .s_sda_o(bi.s_sda_o), .s_sda_oe(bi.s_sda_oe),
		.hw_enable_reset_pin(bi.hw_enable_reset_pin), .scl(bi.scl), .sda(bi.sda));
	// count write strobes and capture the first wire byte after each start
	always @(posedge clk) begin
		if (wr_stb === 1'b1) stb_count++;
		if (bi.scl && scl_p && sda_p && !bi.sda) begin
			mon_n <= 4'h0;
		end else if (bi.scl && !scl_p && mon_n < 4'h8) begin
			mon_b <= {mon_b[6:0], bi.sda};
			mon_n <= mon_n + 4'h1;
		end
		scl_p <= bi.scl;
		sda_p <= bi.sda;
	end
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one controller transfer, waits for done under a bound
	task automatic xfer(input logic r, input logic [7:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		#5;
		rw = r;
		reg_addr = a;
		wdata = d;
		req = 1'b1;
		@(posedge clk);
		#5;
		req = 1'b0;
		while (done !== 1'b1 && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
			if (n == 100) mid_busy = {busy, bus_busy};
		end
		check("done", {7'h00, done}, 8'h01);
		check("host free", {7'h00, busy}, 8'h00);
		repeat (10) @(posedge clk);
	endtask
	// hand driver on the second link, one quarter is five clocks
	task automatic qtr(input int n);
		repeat (5 * n) @(posedge clk);
		#5;
	endtask
	task automatic bb_start();
		bx.m_sda_oe = 1'b0;
		qtr(1);
		bx.scl_oe = 1'b0;
		qtr(1);
		bx.m_sda_oe = 1'b1;
		qtr(1);
		bx.scl_oe = 1'b1;
		qtr(1);
	endtask
	task automatic bb_byte(input logic [7:0] b, output logic a);
		for (int i = 8; i >= 0; i--) begin
			bx.m_sda_oe = (i == 0) ? 1'b0 : !b[i-1];
			qtr(1);
			bx.scl_oe = 1'b0;
			qtr(2);
			a = !bx.sda;
			bx.scl_oe = 1'b1;
			qtr(1);
		end
	endtask
	initial begin
		#2000000;
		fail_count++;
		final_report();
	end
	initial begin
		bx.scl_o = 1'b0;
		bx.scl_oe = 1'b0;
		bx.m_sda_o = 1'b0;
		bx.m_sda_oe = 1'b0;
		bx.hw_enable_reset_pin = 1'b1;
		mid_busy = 2'h0;
		repeat (8) @(posedge clk);
		#5;
		rst_n = 1'b1;
		en_req = 1'b1;
		repeat (20) @(posedge clk);
		check("enabled", {7'h00, dev_enabled}, 8'h01);
		for (int i = 0; i < 16; i++) check("reg reset", regs[8*i +: 8], 8'h00);
		$display("test reset done");
		xfer(1'b0, 8'h03, 8'ha5);
		check("busy mid", {6'h00, mid_busy}, 8'h03);
		check("busy after", {7'h00, bus_busy}, 8'h00);
		check("nack", {7'h00, nack}, 8'h00);
		check("addr byte", mon_b, 8'h70);
		check("stores", 8'(stb_count), 8'h01);
		check("wr addr", wr_addr, 8'h03);
		check("wr data", wr_data, 8'ha5);
		check("reg3", regs[31:24], 8'ha5);
		xfer(1'b1, 8'h03, 8'h00);
		check("read3", rdata, 8'ha5);
		check("read addr byte", mon_b, 8'h71);
		check("stores read", 8'(stb_count), 8'h01);
		xfer(1'b0, 8'h0f, 8'hc1);
		xfer(1'b1, 8'h0f, 8'h00);
		check("read15", rdata, 8'hc1);
		$display("test write read done");
		xfer(1'b0, 8'h00, 8'h01);
		check("soft bit", regs[7:0], 8'h00);
		check("soft reg3", regs[31:24], 8'h00);
		check("soft reg15", regs[127:120], 8'h00);
		$display("test soft reset done");
		xfer(1'b0, 8'h02, 8'h3c);
		check("reg2", regs[23:16], 8'h3c);
		@(posedge clk);
		#5;
		en_req = 1'b0;
		repeat (10) @(posedge clk);
		check("disabled", {7'h00, dev_enabled}, 8'h00);
		check("pin reg2", regs[23:16], 8'h00);
		#5;
		en_req = 1'b1;
		repeat (20) @(posedge clk);
		check("reenabled", {7'h00, dev_enabled}, 8'h01);
		$display("test enable pin done");
		bb_start();
		bb_byte(8'h72, ack);
		check("foreign ack", {7'h00, ack}, 8'h00);
		bb_byte(8'h70, ack);
		check("ignored ack", {7'h00, ack}, 8'h00);
		bb_start();
		bb_byte(8'h70, ack);
		check("restart ack", {7'h00, ack}, 8'h01);
		bb_byte(8'h05, ack);
		bb_byte(8'h77, ack);
		check("data ack", {7'h00, ack}, 8'h01);
		bx.m_sda_oe = 1'b1;
		qtr(1);
		bx.scl_oe = 1'b0;
		qtr(1);
		bx.m_sda_oe = 1'b0;
		qtr(2);
		check("idle lines", {6'h00, bx.scl, bx.sda}, 8'h03);
		check("hand reg5", regs2[47:40], 8'h77);
		$display("test hand driver done");
		final_report();
	end
endmodule
`default_nettype wire
